//--- msp_map.vh
// Address map, field layout, reset values and timing for the speed program.
// Assumes a 40 MHz system clock and a byte-addressed Wishbone bus.
`ifndef MSP_MAP_VH
`define MSP_MAP_VH

// Word offsets (byte addresses)
`define MSP_ADR_MODE_SEL    8'h00
`define MSP_ADR_RUN_MODE    8'h04
`define MSP_ADR_DIR_LOW     8'h08
`define MSP_ADR_DIR_HIGH    8'h0C
`define MSP_ADR_RAMP_LOW    8'h10
`define MSP_ADR_RAMP_HIGH   8'h14
`define MSP_ADR_PROG_MEM    8'h18
`define MSP_ADR_UD_MEM      8'h1C
`define MSP_ADR_STATUS      8'h20
`define MSP_ADR_UD_VALUE    8'h24
`define MSP_ADR_FREQ_BASE   8'h40
`define MSP_ADR_TIMER_BASE  8'h80
`define MSP_ADR_ARRAY_MASK  8'hC0

// Field widths and values
`define MSP_FREQ_W          17
`define MSP_TIME_W          16
`define MSP_MODE_INTERNAL   3'h1
`define MSP_MODE_RESET      3'h2
`define MSP_LAST_SEG        4'hF

// Run-mode bits: bit 0 circular, bit 1 stop between segments
`define MSP_RM_CIRC         0
`define MSP_RM_GAP          1

// Sequencer states
`define MSP_ST_IDLE         2'h0
`define MSP_ST_RUN          2'h1
`define MSP_ST_GAP          2'h2

// One time step is 0.1 s; period of sys_clk in ns
`define MSP_STEP_NS         100000000
`define MSP_CLK_NS          25
`define MSP_STEP_CYCLES     (`MSP_STEP_NS / `MSP_CLK_NS)

`endif

//--- msp_speed_program.v
// Internal sixteen-segment speed sequencer with Wishbone register file.
// Assumes run/stop/fault inputs are one-cycle pulses synchronous to sys_clk.
// The motor rest flag is likewise taken as synchronous to sys_clk.
`timescale 1ns/1ps
`include "msp_map.vh"

module msp_speed_program #(
  parameter TICK_CYCLES = `MSP_STEP_CYCLES
) (
  input  wire                    sys_clk,
  input  wire                    rst,
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [7:0]              wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  input  wire                    run_cmd,
  input  wire                    stop_cmd,
  input  wire                    ext_fault,
  input  wire                    emerg_stop,
  input  wire                    motor_stopped,
  input  wire                    power_lost,
  input  wire                    updown_load,
  input  wire [`MSP_FREQ_W-1:0]  updown_value,
  output reg  [`MSP_FREQ_W-1:0]  freq_out,
  output reg                     reverse_out,
  output reg  [1:0]              ramp_sel_out,
  output reg                     drive_run,
  output reg  [3:0]              seg_index,
  output reg                     pass_done,
  output reg  [`MSP_TIME_W-1:0]  draft_time_out,
  output reg  [`MSP_FREQ_W-1:0]  updown_hold
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  // Written only from the bus; the sequencer reads it every cycle, so a
  // setpoint changed while a segment runs reaches the output at once
  reg [2:0]              mode_sel_q;           // Speed mode selection
  reg [1:0]              run_mode_q;           // Program run mode
  reg [7:0]              dir_low_q;            // Direction, segments 1-8
  reg [7:0]              dir_high_q;           // Direction, segments 9-16
  reg [15:0]             ramp_low_q;           // Ramp codes, segments 1-8
  reg [15:0]             ramp_high_q;          // Ramp codes, segments 9-16
  reg                    prog_mem_q;           // Program memory option
  reg                    ud_mem_q;             // Up/down memory option
  reg [`MSP_FREQ_W-1:0]  freq_q [0:15];        // Index 0 is main setpoint
  reg [`MSP_TIME_W-1:0]  timer_q [0:15];       // Running time in 0.1 s

  // Sequencer state
  // Index, elapsed steps and tick survive a stop when memory is on; they
  // are cleared in IDLE otherwise, so a fresh run starts at segment one
  reg [1:0]              state_q;              // IDLE / RUN / GAP
  reg [3:0]              idx_q;                // Active segment
  reg [`MSP_TIME_W-1:0]  elapsed_q;            // Steps spent in segment
  reg [21:0]             tick_q;               // Cycles within a step
  reg                    resume_q;             // Saved position is valid
  reg                    seen_q;               // Pass held a live segment

  integer i;                                   // Reset loop index

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Run commands are left out of the kill term on purpose: once running,
  // only stop, external fault, emergency stop, a mode change or the end of a single pass end the run,
  // which keeps circular running deaf to a stray run command
  wire                   prog_sel   = (mode_sel_q == `MSP_MODE_INTERNAL);
  wire                   circ       = run_mode_q[`MSP_RM_CIRC];
  wire                   gap_mode   = run_mode_q[`MSP_RM_GAP];
  wire [15:0]            dir_all    = {dir_high_q, dir_low_q};
  wire [31:0]            ramp_all   = {ramp_high_q, ramp_low_q};
  wire [`MSP_TIME_W-1:0] cur_time   = timer_q[idx_q];
  wire                   seg_live   = (cur_time != {`MSP_TIME_W{1'b0}});
  wire                   seg_end    = (elapsed_q >= cur_time);
  // Step strobe divides sys_clk down to the 0.1 s time step
  wire                   step       = (tick_q == TICK_CYCLES[21:0] - 22'h000001);
  wire                   kill       = stop_cmd | ext_fault | emerg_stop | ~prog_sel;
  // Bus request and address decode
  wire                   wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                   in_array   = (wb_adr_i & `MSP_ADR_ARRAY_MASK) != 8'h00;
  wire [3:0]             arr_idx    = wb_adr_i[5:2];
  wire                   is_freq    = (wb_adr_i & `MSP_ADR_ARRAY_MASK) == `MSP_ADR_FREQ_BASE;
  wire                   is_timer   = (wb_adr_i & `MSP_ADR_ARRAY_MASK) == `MSP_ADR_TIMER_BASE;
  wire [31:0]            byte_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Merge write data into an old word under the byte lanes
  // Used once, for the write word below the read mux
  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] mask;
    begin
      merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read mux for the bus
  // Purely combinational; the registered copy goes out with ack, so the
  // address may change freely once the access is over
  reg [31:0] rd_data;                          // Word chosen for a read
  always @* begin
    rd_data = 32'h00000000;
    if (is_freq) begin
      rd_data = {15'h0000, freq_q[arr_idx]};
    end else if (is_timer) begin
      rd_data = {16'h0000, timer_q[arr_idx]};
    end else if (!in_array) begin
      case (wb_adr_i)
        `MSP_ADR_MODE_SEL:  rd_data = {29'h00000000, mode_sel_q};
        `MSP_ADR_RUN_MODE:  rd_data = {30'h00000000, run_mode_q};
        `MSP_ADR_DIR_LOW:   rd_data = {24'h000000, dir_low_q};
        `MSP_ADR_DIR_HIGH:  rd_data = {24'h000000, dir_high_q};
        `MSP_ADR_RAMP_LOW:  rd_data = {16'h0000, ramp_low_q};
        `MSP_ADR_RAMP_HIGH: rd_data = {16'h0000, ramp_high_q};
        `MSP_ADR_PROG_MEM:  rd_data = {31'h00000000, prog_mem_q};
        `MSP_ADR_UD_MEM:    rd_data = {31'h00000000, ud_mem_q};
        // Live sequencer state for software
        `MSP_ADR_STATUS:    rd_data = {23'h000000, seen_q, resume_q, state_q, idx_q,
                                       drive_run};
        `MSP_ADR_UD_VALUE:  rd_data = {15'h0000, updown_hold};
        default:            rd_data = 32'h00000000;   // Unmapped reads zero
      endcase
    end
  end

  // Write word: the addressed register as it reads now, with the enabled
  // byte lanes replaced; sharing the read mux keeps both views in step,
  // and each register below keeps only the bits of its own field
  wire [31:0]            wr_word    = merge(rd_data, wb_dat_i, byte_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one-cycle registered ack, unmapped writes dropped
  // A request is taken at the edge where cyc and stb are high and ack is
  // low; the ack term keeps a held strobe from being taken twice, and the
  // write lands at that same edge
  always @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      mode_sel_q  <= `MSP_MODE_RESET;
      run_mode_q  <= 2'h0;
      dir_low_q   <= 8'h00;
      dir_high_q  <= 8'h00;
      ramp_low_q  <= 16'h0000;
      ramp_high_q <= 16'h0000;
      prog_mem_q  <= 1'b0;
      ud_mem_q    <= 1'b0;
      // Setpoints and timers clear, so every segment starts unused
      for (i = 0; i < 16; i = i + 1) begin
        freq_q[i]  <= {`MSP_FREQ_W{1'b0}};
        timer_q[i] <= {`MSP_TIME_W{1'b0}};
      end
    end else begin
      wb_ack_o <= wb_req;
      // Read data is registered together with the ack
      if (wb_req) begin
        wb_dat_o <= rd_data;
      end
      if (wb_req && wb_we_i) begin
        if (is_freq) begin
          // Setpoints in 0.01 Hz units; bits above the field are dropped
          freq_q[arr_idx] <= wr_word[`MSP_FREQ_W-1:0];
        end else if (is_timer) begin
          // Running time in 0.1 s steps; zero leaves the segment out
          timer_q[arr_idx] <= wr_word[`MSP_TIME_W-1:0];
        end else begin
          case (wb_adr_i)
            // Only the internal-program value lets the sequencer run
            `MSP_ADR_MODE_SEL:  mode_sel_q  <= wr_word[2:0];
            // Bit 0 circular, bit 1 stop between segments
            `MSP_ADR_RUN_MODE:  run_mode_q  <= wr_word[1:0];
            // One direction bit per segment, set means reverse
            `MSP_ADR_DIR_LOW:   dir_low_q   <= wr_word[7:0];
            // Same layout for the upper eight segments
            `MSP_ADR_DIR_HIGH:  dir_high_q  <= wr_word[7:0];
            // Two ramp bits per segment, segment one lowest
            `MSP_ADR_RAMP_LOW:  ramp_low_q  <= wr_word[15:0];
            // Same packing for the upper eight segments
            `MSP_ADR_RAMP_HIGH: ramp_high_q <= wr_word[15:0];
            // Keeps the program position across a stop or fault
            `MSP_ADR_PROG_MEM:  prog_mem_q  <= wr_word[0];
            // Keeps the up/down value across a stop
            `MSP_ADR_UD_MEM:    ud_mem_q    <= wr_word[0];
            default:            ud_mem_q    <= ud_mem_q;  // Read-only or unmapped
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one segment skipped per cycle when its time is zero
  // A live segment lasts its timer in steps plus one cycle for the end
  // test; the extra cycle is the price of a registered compare. A circular
  // program with no live segment ends like a single pass rather than spin
  always @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= `MSP_ST_IDLE;
      idx_q     <= 4'h0;
      elapsed_q <= {`MSP_TIME_W{1'b0}};
      tick_q    <= 22'h000000;
      resume_q  <= 1'b0;
      seen_q    <= 1'b0;
      pass_done <= 1'b0;
    end else begin
      pass_done <= 1'b0;
      case (state_q)
        `MSP_ST_IDLE: begin
          // Fresh start unless a saved position is held
          // Turning memory off while idle discards a saved position
          if (!resume_q || !prog_mem_q) begin
            idx_q     <= 4'h0;
            elapsed_q <= {`MSP_TIME_W{1'b0}};
            tick_q    <= 22'h000000;
            seen_q    <= 1'b0;
          end
          if (run_cmd && prog_sel && !stop_cmd && !ext_fault && !emerg_stop) begin
            state_q  <= `MSP_ST_RUN;
            resume_q <= 1'b0;
          end
        end
        `MSP_ST_RUN: begin
          // Run commands fall through unused here
          // Kill is tested first so a stop wins over a segment change
          if (kill) begin
            state_q  <= `MSP_ST_IDLE;
            resume_q <= prog_mem_q;
          end else if (seg_end) begin
            elapsed_q <= {`MSP_TIME_W{1'b0}};
            tick_q    <= 22'h000000;
            // Only a live segment is followed by a stop interval
            if (seg_live && gap_mode) begin
              state_q <= `MSP_ST_GAP;
            end
            if (idx_q == `MSP_LAST_SEG) begin
              idx_q  <= 4'h0;
              seen_q <= 1'b0;
              // Single pass, or a pass with no live segment, ends the run
              if (!circ || !(seen_q || seg_live)) begin
                state_q   <= `MSP_ST_IDLE;
                pass_done <= 1'b1;
              end
            end else begin
              // Next segment in order
              idx_q <= idx_q + 4'h1;
              if (seg_live) begin
                seen_q <= 1'b1;
              end
            end
          end else if (step) begin
            tick_q    <= 22'h000000;
            elapsed_q <= elapsed_q + {{(`MSP_TIME_W-1){1'b0}}, 1'b1};
          end else begin
            tick_q <= tick_q + 22'h000001;
          end
        end
        `MSP_ST_GAP: begin
          // Output held off until the motor has come to rest
          // A kill here keeps the following segment as the resume point
          if (kill) begin
            state_q  <= `MSP_ST_IDLE;
            resume_q <= prog_mem_q;
          end else if (motor_stopped) begin
            state_q <= `MSP_ST_RUN;
          end
        end
        default: begin
          state_q <= `MSP_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive outputs, registered; zero-time segments never reach the output
  // While a zero-time segment is skipped the last live values are held, so
  // the ramp generator sees no short dip between two live segments
  always @(posedge sys_clk) begin
    if (rst) begin
      // Output stage disabled and at zero
      freq_out       <= {`MSP_FREQ_W{1'b0}};
      reverse_out    <= 1'b0;
      ramp_sel_out   <= 2'h0;
      drive_run      <= 1'b0;
      seg_index      <= 4'h0;
      draft_time_out <= {`MSP_TIME_W{1'b0}};
    end else begin
      // Index follows the sequencer and draft time the segment-one timer, one cycle late
      seg_index      <= idx_q;
      draft_time_out <= timer_q[0];
      if (state_q == `MSP_ST_RUN && seg_live && prog_sel) begin
        drive_run    <= 1'b1;
        freq_out     <= freq_q[idx_q];
        reverse_out  <= dir_all[idx_q];
        ramp_sel_out <= ramp_all[{idx_q, 1'b0} +: 2];
      end else if (state_q == `MSP_ST_IDLE || state_q == `MSP_ST_GAP) begin
        drive_run    <= 1'b0;
        freq_out     <= {`MSP_FREQ_W{1'b0}};
        reverse_out  <= 1'b0;
        ramp_sel_out <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Up/down adjustment hold; a new load wins over any clear
  // A power loss keeps the value only when both memory options are on; a
  // stop keeps it when the up/down option alone is on
  always @(posedge sys_clk) begin
    if (rst) begin
      updown_hold <= {`MSP_FREQ_W{1'b0}};
    end else if (updown_load) begin
      updown_hold <= updown_value;
    end else if (power_lost && !(ud_mem_q && prog_mem_q)) begin
      updown_hold <= {`MSP_FREQ_W{1'b0}};
    end else if (stop_cmd && !ud_mem_q) begin
      updown_hold <= {`MSP_FREQ_W{1'b0}};
    end
  end

endmodule

//--- msp_checker.sv
// Port checker for the speed program: bus handshake, halts, pulses.
// Assumes one clock domain, sync reset and a one-cycle registered ack.
`timescale 1ns/1ps
`include "msp_map.vh"
module msp_checker (
  input wire                   sys_clk,
  input wire                   rst,
  input wire                   wb_cyc_i,
  input wire                   wb_stb_i,
  input wire                   wb_we_i,
  input wire [7:0]             wb_adr_i,
  input wire [31:0]            wb_dat_o,
  input wire                   wb_ack_o,
  input wire                   stop_cmd,
  input wire                   ext_fault,
  input wire                   emerg_stop,
  input wire                   updown_load,
  input wire [`MSP_FREQ_W-1:0] updown_value,
  input wire [`MSP_FREQ_W-1:0] freq_out,
  input wire                   drive_run,
  input wire                   pass_done,
  input wire [`MSP_FREQ_W-1:0] updown_hold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Bus answers exactly one cycle after a request is taken
  property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  // Hole in the map reads as zero
  property p_hole_zero;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i inside {[8'h28:8'h3C]}
    |=> wb_dat_o == 32'h0;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("hole not zero");
  property p_idle_freq; !drive_run |-> freq_out == 0; endproperty
  a_idle_freq: assert property (p_idle_freq) else $error("freq while off");
  // Stop and fault end the run two edges later
  property p_halt; stop_cmd || ext_fault |-> ##2 !drive_run; endproperty
  a_halt: assert property (p_halt) else $error("run after stop");
  property p_estop; emerg_stop |-> ##2 (!drive_run && freq_out == 0); endproperty
  a_estop: assert property (p_estop) else $error("run after estop");
  property p_pass_pulse; pass_done |=> !pass_done; endproperty
  a_pass_pulse: assert property (p_pass_pulse) else $error("pass wide");
  property p_pass_off; pass_done |-> ##1 !drive_run; endproperty
  a_pass_off: assert property (p_pass_off) else $error("run after pass");
  property p_ud_load; updown_load |=> updown_hold == $past(updown_value); endproperty
  a_ud_load: assert property (p_ud_load) else $error("updown not loaded");
endmodule

//--- msp_motor_model.sv
// Motor and ramp stage model: reports rest a set time after output stops.
// Assumes drive_run is the enable of the output stage.
`timescale 1ns/1ps
module msp_motor_model (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       drive_run,
  input  wire [7:0] coast,
  output reg        motor_stopped
);
  reg [7:0] cnt_q; // Cycles spent coasting
  // Motor coasts down, so rest is reported late, never at once
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      motor_stopped <= 1'b1;
    end else if (drive_run) begin
      cnt_q <= 8'h00;
      motor_stopped <= 1'b0;
    end else if (cnt_q >= coast) begin
      motor_stopped <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench for the speed program: map, run modes, memory.
// Assumes the checker and motor model are compiled before this file.
`timescale 1ns/1ps
`include "msp_map.vh"
module testbench;
  localparam  TICK = 4;
  reg         sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg  [7:0]  wb_adr_i = 0, coast = 1;
  reg  [31:0] wb_dat_i = 0, rdat, rampw;
  reg  [4:0]  cmd = 0; // {power_lost, emerg_stop, ext_fault, stop_cmd, run_cmd}
  reg         updown_load = 0, busy = 0, saw12 = 0;
  reg  [16:0] updown_value = 0, frq [0:15];
  reg  [15:0] tmr [0:15], dirm;
  reg  [3:0]  s1 = 0, s2 = 0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, reverse_out, drive_run, pass_done, motor_stopped;
  wire [1:0]  ramp_sel_out;
  wire [3:0]  seg_index;
  wire [16:0] freq_out, updown_hold;
  wire [15:0] draft_time_out;
  integer     seed = 32'h54a2, failures = 0, cmp_count = 0, tick = 0;
  integer     i, m, n5, n12, lows, passes, wraps;
  always #12.5 sys_clk = ~sys_clk;
  msp_speed_program #(.TICK_CYCLES(TICK)) dut (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .run_cmd(cmd[0]), .stop_cmd(cmd[1]), .ext_fault(cmd[2]), .emerg_stop(cmd[3]),
    .motor_stopped(motor_stopped), .power_lost(cmd[4]), .updown_load(updown_load),
    .updown_value(updown_value), .freq_out(freq_out), .reverse_out(reverse_out),
    .ramp_sel_out(ramp_sel_out), .drive_run(drive_run), .seg_index(seg_index),
    .pass_done(pass_done), .draft_time_out(draft_time_out), .updown_hold(updown_hold));
  msp_motor_model motor (.sys_clk(sys_clk), .rst(rst), .drive_run(drive_run),
    .coast(coast), .motor_stopped(motor_stopped));
  ////////////////////////////////////////////////////////////////////////////
  function [1:0] exp_ramp(input [3:0] s);
    exp_ramp = rampw[2*s +: 2];
  endfunction
  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Classic single cycle; holds the request until ack is sampled
  task xfer(input [7:0] a, input we, input [31:0] d);
    begin
      @(posedge sys_clk);
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      rdat = wb_dat_o;
      wb_cyc_i <= 0; wb_stb_i <= 0;
    end
  endtask
  task pulse(input [4:0] v);
    begin
      @(posedge sys_clk); cmd <= v;
      @(posedge sys_clk); cmd <= 0;
    end
  endtask
  task wait_cyc(input integer n); repeat (n) @(posedge sys_clk); endtask
  // Hang is cut by the cycle ceiling below
  task wait_seg(input [3:0] s);
    begin
      @(posedge sys_clk);
      while (!(drive_run === 1'b1 && seg_index == s)) @(posedge sys_clk);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Segment outputs checked once the index has settled two cycles
  always @(posedge sys_clk) begin
    s1 <= seg_index; s2 <= s1;
    if (drive_run === 1'b1 && seg_index == s1 && s1 == s2) begin
      chk(freq_out, frq[seg_index]);
      chk(reverse_out, dirm[seg_index]);
      chk(ramp_sel_out, exp_ramp(seg_index));
    end
    if (drive_run === 1'b1) busy = 1;
    if (drive_run === 1'b1 && seg_index == 5) n5 = n5 + 1;
    if (drive_run === 1'b1 && seg_index == 12) begin n12 = n12 + 1; saw12 = 1; end
    if (drive_run === 1'b1 && seg_index == 0 && saw12) begin wraps = wraps + 1; saw12 = 0; end
    if (drive_run === 1'b0 && busy) lows = lows + 1;
    if (pass_done === 1'b1) passes = passes + 1;
    tick = tick + 1;
    if (tick == 40000) begin
      failures = failures + 1;
      $display("wrong value at %0t: run timed out", $time);
      final_report;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    xfer(`MSP_ADR_MODE_SEL, 0, 0); chk(rdat, 2);
    xfer(8'h30, 0, 0); chk(rdat, 0);
    for (i = 0; i < 16; i = i + 1) begin
      frq[i] = {$random(seed)} % 99984;
      frq[i][3:0] = i[3:0];
      tmr[i] = (i == 0 || i == 5) ? 1 : (i == 12) ? 3 : 0;
      xfer(`MSP_ADR_FREQ_BASE + {i[5:0], 2'b00}, 1, frq[i]);
      xfer(`MSP_ADR_TIMER_BASE + {i[5:0], 2'b00}, 1, tmr[i]);
    end
    dirm = $random(seed); rampw = $random(seed);
    xfer(`MSP_ADR_DIR_LOW, 1, dirm[7:0]); xfer(`MSP_ADR_DIR_HIGH, 1, dirm[15:8]);
    xfer(`MSP_ADR_RAMP_LOW, 1, rampw[15:0]); xfer(`MSP_ADR_RAMP_HIGH, 1, rampw[31:16]);
    xfer(`MSP_ADR_DIR_LOW, 0, 0); chk(rdat, dirm[7:0]);
    chk(draft_time_out, tmr[0]);
    xfer(`MSP_ADR_MODE_SEL, 1, 0); pulse(5'h01); wait_cyc(6);
    chk(drive_run, 0);
    xfer(`MSP_ADR_MODE_SEL, 1, 1);
    $display("test setup done");
    for (m = 0; m < 4; m = m + 1) begin
      coast <= m[1] ? 20 + ({$random(seed)} % 16) : 1;
      xfer(`MSP_ADR_RUN_MODE, 1, m);
      n5 = 0; n12 = 0; lows = 0; passes = 0; wraps = 0; busy = 0; saw12 = 0;
      pulse(5'h01); wait_seg(12); pulse(5'h01); wait_cyc(2);
      chk(seg_index, 12);
      if (!m[0]) begin
        while (passes == 0) @(posedge sys_clk);
        chk(lows >= 40, m[1]);
        chk(n12 - n5, 2 * TICK);
        wait_cyc(40); chk(drive_run, 0);
        chk(passes, 1);
        pulse(5'h01); wait_seg(0); pulse(5'h08);
      end else begin
        while (wraps < 2) @(posedge sys_clk);
        chk(passes, 0);
        chk(lows >= 40, m[1]);
        pulse(m == 1 ? 5'h02 : 5'h04); wait_cyc(3);
        chk(drive_run, 0);
      end
      busy = 0; wait_cyc(40);
      $display("test run mode %0d done", m);
    end
    xfer(`MSP_ADR_RUN_MODE, 1, 0);
    for (m = 1; m >= 0; m = m - 1) begin
      xfer(`MSP_ADR_PROG_MEM, 1, m);
      pulse(5'h01); wait_seg(5); pulse(5'h02); wait_cyc(4); pulse(5'h01);
      while (drive_run !== 1'b1) @(posedge sys_clk);
      chk(seg_index, m ? 5 : 0);
      pulse(5'h08); wait_cyc(40);
    end
    $display("test program memory done");
    for (m = 0; m < 4; m = m + 1) begin
      xfer(`MSP_ADR_UD_MEM, 1, m[0]); xfer(`MSP_ADR_PROG_MEM, 1, m[1]);
      for (i = 0; i < 2; i = i + 1) begin
        @(posedge sys_clk);
        updown_load <= 1; updown_value <= {$random(seed)} % 100000;
        @(posedge sys_clk);
        updown_load <= 0;
        pulse(i ? 5'h10 : 5'h02); wait_cyc(2);
        chk(updown_hold, (i ? m == 3 : m[0]) ? updown_value : 17'h0);
      end
    end
    $display("test updown memory done");
    final_report;
  end
endmodule
bind msp_speed_program msp_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_cmd(stop_cmd), .ext_fault(ext_fault),
  .emerg_stop(emerg_stop), .updown_load(updown_load), .updown_value(updown_value),
  .freq_out(freq_out), .drive_run(drive_run), .pass_done(pass_done),
  .updown_hold(updown_hold));
